// ==== scb_pkg.sv ====
// shared constants for the smbus clock buffer configuration port and its host
package scb_pkg;
	localparam int NUM_OUT = 7;
	// register indices
	localparam logic [7:0] REG_OUT_EN = 8'h00;
	localparam logic [7:0] REG_EN6_AMP = 8'h01;
	localparam logic [7:0] REG_SLEW = 8'h02;
	localparam logic [7:0] REG_SLEW6 = 8'h03;
	localparam logic [7:0] REG_RSVD = 8'h04;
	localparam logic [7:0] REG_REV_MAKER = 8'h05;
	localparam logic [7:0] REG_DEV_CODE = 8'h06;
	localparam logic [7:0] REG_COUNT = 8'h07;
	// reset values and reserved read levels
	localparam logic [6:0] EN_RESET = 7'h7f;
	localparam logic [6:0] SLEW_RESET = 7'h7f;
	localparam logic [1:0] AMP_RESET = 2'h2;
	localparam logic [4:0] COUNT_RESET = 5'h08;
	localparam logic [7:0] RSVD0_BITS = 8'h22;
	localparam logic [7:0] RSVD1_BITS = 8'hdc;
	localparam logic [7:0] RSVD2_BITS = 8'h22;
	localparam logic [7:0] RSVD3_BITS = 8'h44;
	localparam logic [7:0] RSVD4_BITS = 8'hff;
	localparam int BYTE_ACK_SLOT = 8;
	// host register map (apb byte addresses)
	localparam logic [7:0] HOST_CTRL = 8'h00;
	localparam logic [7:0] HOST_STATUS = 8'h04;
	localparam logic [7:0] HOST_BUF_BASE = 8'h40;
	localparam int HOST_BUF_DEPTH = 32;
	localparam int HOST_QUARTER_CYC = 25;
	typedef enum {ST_IDLE, ST_ADDR, ST_INDEX, ST_COUNT, ST_WDATA, ST_RDATA, ST_SKIP} scb_dev_st_t;
endpackage

// ==== scb_if.sv ====
// two-wire link between the buffer's configuration port and its host
`timescale 1ns/1ps
interface scb_if;
	logic host_scl_o;
	logic host_scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic scl;
	logic sda;
	// open-drain wires with pull-ups: any enabled driver pulls low
	assign scl = host_scl_oe_n ? 1'b1 : host_scl_o;
	assign sda = (host_sda_oe_n ? 1'b1 : host_sda_o) & (dev_sda_oe_n ? 1'b1 : dev_sda_o);
	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
	modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n,
		output host_sda_o, output host_sda_oe_n);
endinterface

// ==== scb_dev.sv ====
// clock buffer configuration target: smbus indexed block access and register bank
//
// Our own choice: register access over the two-wire link, with the host commanded over APB.
`timescale 1ns/1ps
module scb_dev #(
	parameter logic [6:0] ADDR_LOW = 7'h50,
	parameter logic [6:0] ADDR_MID = 7'h51,
	parameter logic [6:0] ADDR_HIGH = 7'h52,
	parameter logic [3:0] REV_CODE = 4'h3,   // arbitrary value
	parameter logic [3:0] MAKER_CODE = 4'h5, // arbitrary value
	parameter logic [7:0] DEV_CODE = 8'ha5   // arbitrary value
) (
	input  wire logic                         clk,
	input  wire logic                         arst_n,
	scb_if.dev                                bus,
	input  wire logic [1:0]                   target_address_select_pin,
	input  wire logic [scb_pkg::NUM_OUT-1:0]  clock_out_enable_pin_n,
	output logic      [scb_pkg::NUM_OUT-1:0]  differential_clock_output_en,
	output logic      [scb_pkg::NUM_OUT-1:0]  edge_speed_fast,
	output logic      [1:0]                   amplitude_sel
);
	import scb_pkg::*;

	logic [2:0]          scl_s;
	logic [2:0]          sda_s;
	logic [1:0]          asel_s0;
	logic [1:0]          asel_s1;
	logic [1:0]          asel_fill_reg;
	logic [NUM_OUT-1:0]  oe_s0;
	logic [NUM_OUT-1:0]  oe_s1;
	logic                addr_latched_reg;
	logic [6:0]          my_addr_reg;
	scb_dev_st_t         st_reg;
	logic [3:0]          bit_cnt_reg;
	logic                ack_slot_reg;
	logic                nacked_reg;
	logic                first_reg;
	logic [7:0]          sh_reg;
	logic [7:0]          tx_reg;
	logic [7:0]          ptr_reg;
	logic [7:0]          left_reg;
	logic                sda_oe_n_reg;
	logic                we_reg;
	logic [7:0]          wa_reg;
	logic [7:0]          wd_reg;
	logic [NUM_OUT-1:0]  en_reg;
	logic [NUM_OUT-1:0]  slew_reg;
	logic [1:0]          amp_reg;
	logic [4:0]          count_reg;
	logic [7:0]          rd_byte;
	logic                scl_rise;
	logic                scl_fall;
	logic                start_cond;
	logic                stop_cond;

	// register read mux; unmapped indices read zero
	function automatic logic [7:0] reg_read(input logic [7:0] idx);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			REG_OUT_EN:    v = RSVD0_BITS | {en_reg[5:4], 1'b0, en_reg[3:1], 1'b0, en_reg[0]};
			REG_EN6_AMP:   v = RSVD1_BITS | {2'b00, en_reg[6], 3'b000, amp_reg};
			REG_SLEW:      v = RSVD2_BITS | {slew_reg[5:4], 1'b0, slew_reg[3:1], 1'b0, slew_reg[0]};
			REG_SLEW6:     v = RSVD3_BITS | {7'h00, slew_reg[6]};
			REG_RSVD:      v = RSVD4_BITS;
			REG_REV_MAKER: v = {REV_CODE, MAKER_CODE};
			REG_DEV_CODE:  v = DEV_CODE;
			REG_COUNT:     v = {3'b000, count_reg};
			default:       v = 8'h00;
		endcase
		return v;
	endfunction

	// pin synchronisers; stage 0 feeds stage 1 only
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			scl_s   <= 3'h7;
			sda_s   <= 3'h7;
			asel_s0 <= 2'h0;
			asel_s1 <= 2'h0;
			oe_s0   <= 7'h7f;
			oe_s1   <= 7'h7f;
		end
		else
		begin
			scl_s   <= {scl_s[1:0], bus.scl};
			sda_s   <= {sda_s[1:0], bus.sda};
			asel_s0 <= target_address_select_pin;
			asel_s1 <= asel_s0;
			oe_s0   <= clock_out_enable_pin_n;
			oe_s1   <= oe_s0;
		end
	end

	assign scl_rise   = scl_s[1] & ~scl_s[2];
	assign scl_fall   = ~scl_s[1] & scl_s[2];
	assign start_cond = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
	assign stop_cond  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
	assign rd_byte    = first_reg ? {3'b000, count_reg} : reg_read(ptr_reg);

	// address is caught once after reset release, later pin moves are ignored;
	// the catch waits until the sync stages hold the pin and not their reset value
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			asel_fill_reg    <= 2'h0;
			addr_latched_reg <= 1'b0;
			my_addr_reg      <= 7'h00;
		end
		else
		begin
			asel_fill_reg <= {asel_fill_reg[0], 1'b1};
			if (asel_fill_reg[1] && !addr_latched_reg)
			begin
				addr_latched_reg <= 1'b1;
				my_addr_reg      <= asel_s1[1] ? ADDR_HIGH :
					(asel_s1[0] ? ADDR_MID : ADDR_LOW);
			end
		end
	end

	// protocol engine: bits taken on scl rise, sda changed only after scl fall
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_reg       <= ST_IDLE;
			bit_cnt_reg  <= 4'h0;
			ack_slot_reg <= 1'b0;
			nacked_reg   <= 1'b0;
			first_reg    <= 1'b0;
			sh_reg       <= 8'h00;
			tx_reg       <= 8'h00;
			ptr_reg      <= 8'h00;
			left_reg     <= 8'h00;
			sda_oe_n_reg <= 1'b1;
			we_reg       <= 1'b0;
			wa_reg       <= 8'h00;
			wd_reg       <= 8'h00;
		end
		else
		begin
			we_reg <= 1'b0;
			if (start_cond)
			begin
				// a repeated start also lands here; the pointer is kept
				st_reg       <= ST_ADDR;
				bit_cnt_reg  <= 4'h0;
				ack_slot_reg <= 1'b0;
				nacked_reg   <= 1'b0;
				sda_oe_n_reg <= 1'b1;
			end
			else if (stop_cond)
			begin
				st_reg       <= ST_IDLE;
				ack_slot_reg <= 1'b0;
				sda_oe_n_reg <= 1'b1;
			end
			else if (st_reg != ST_IDLE && st_reg != ST_SKIP)
			begin
				if (scl_rise)
				begin
					if (ack_slot_reg)
					begin
						if (st_reg == ST_RDATA && sda_s[1])
							nacked_reg <= 1'b1;
					end
					else
					begin
						sh_reg      <= {sh_reg[6:0], sda_s[1]};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
				end
				else if (scl_fall)
				begin
					if (ack_slot_reg)
					begin
						// acknowledge slot over: release, or start the next read byte
						ack_slot_reg <= 1'b0;
						bit_cnt_reg  <= 4'h0;
						if (nacked_reg)
						begin
							st_reg       <= ST_SKIP;
							sda_oe_n_reg <= 1'b1;
						end
						else if (st_reg == ST_RDATA)
						begin
							sda_oe_n_reg <= rd_byte[7];
							tx_reg       <= {rd_byte[6:0], 1'b0};
							first_reg    <= 1'b0;
							if (!first_reg)
								ptr_reg <= ptr_reg + 8'h01;
						end
						else
							sda_oe_n_reg <= 1'b1;
					end
					else if (bit_cnt_reg == 4'(BYTE_ACK_SLOT))
					begin
						ack_slot_reg <= 1'b1;
						case (st_reg)
							ST_ADDR:
							begin
								if (sh_reg[7:1] == my_addr_reg)
								begin
									sda_oe_n_reg <= 1'b0;
									first_reg    <= 1'b1;
									st_reg       <= sh_reg[0] ? ST_RDATA : ST_INDEX;
								end
								else
								begin
									ack_slot_reg <= 1'b0;
									st_reg       <= ST_SKIP;
								end
							end
							ST_INDEX:
							begin
								ptr_reg      <= sh_reg;
								sda_oe_n_reg <= 1'b0;
								st_reg       <= ST_COUNT;
							end
							ST_COUNT:
							begin
								left_reg     <= sh_reg;
								sda_oe_n_reg <= 1'b0;
								st_reg       <= ST_WDATA;
							end
							ST_WDATA:
							begin
								sda_oe_n_reg <= 1'b0;
								if (left_reg != 8'h00)
								begin
									we_reg   <= 1'b1;
									wa_reg   <= ptr_reg;
									wd_reg   <= sh_reg;
									ptr_reg  <= ptr_reg + 8'h01;
									left_reg <= left_reg - 8'h01;
								end
							end
							ST_RDATA:
								sda_oe_n_reg <= 1'b1; // host owns this slot
							default:
								sda_oe_n_reg <= 1'b1;
						endcase
					end
					else if (st_reg == ST_RDATA && bit_cnt_reg != 4'h0)
					begin
						sda_oe_n_reg <= tx_reg[7];
						tx_reg       <= {tx_reg[6:0], 1'b0};
					end
				end
			end
		end
	end

	// register bank; read-only and reserved positions drop written bits
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			en_reg    <= EN_RESET;
			slew_reg  <= SLEW_RESET;
			amp_reg   <= AMP_RESET;
			count_reg <= COUNT_RESET;
		end
		else if (we_reg)
		begin
			case (wa_reg)
				REG_OUT_EN:
					en_reg[5:0] <= {wd_reg[7:6], wd_reg[4:2], wd_reg[0]};
				REG_EN6_AMP:
				begin
					en_reg[6] <= wd_reg[5];
					amp_reg   <= wd_reg[1:0];
				end
				REG_SLEW:
					slew_reg[5:0] <= {wd_reg[7:6], wd_reg[4:2], wd_reg[0]};
				REG_SLEW6:
					slew_reg[6] <= wd_reg[0];
				REG_COUNT:
					count_reg <= wd_reg[4:0];
				default:
					count_reg <= count_reg;
			endcase
		end
	end

	// output controls; a cleared enable wins over the enable pin
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			differential_clock_output_en <= 7'h00;
			edge_speed_fast              <= SLEW_RESET;
			amplitude_sel                <= AMP_RESET;
		end
		else
		begin
			differential_clock_output_en <= en_reg & ~oe_s1;
			edge_speed_fast              <= slew_reg;
			amplitude_sel                <= amp_reg;
		end
	end

	assign bus.dev_sda_o    = 1'b0;
	assign bus.dev_sda_oe_n = sda_oe_n_reg;
endmodule

// ==== scb_host.sv ====
// smbus host for indexed block access, commanded over apb
`timescale 1ns/1ps
module scb_host #(
	parameter int QUARTER = scb_pkg::HOST_QUARTER_CYC
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	scb_if.host              bus,
	input  wire logic [6:0]  target_addr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	import scb_pkg::*;

	typedef enum {H_IDLE, H_START, H_BIT, H_STOP} scb_h_st_t;
	typedef enum {SQ_ADDRW, SQ_INDEX, SQ_COUNT, SQ_WDATA, SQ_ADDRR, SQ_RCOUNT, SQ_RDATA} scb_seq_t;

	logic [7:0]  buf_mem [HOST_BUF_DEPTH];
	logic [1:0]  sda_s;
	scb_h_st_t   hst_reg;
	scb_seq_t    seq_reg;
	logic [15:0] div_reg;
	logic [1:0]  q_reg;
	logic [3:0]  bi_reg;
	logic [7:0]  txb_reg;
	logic [7:0]  rxb_reg;
	logic [7:0]  k_reg;
	logic        rd_reg;
	logic [7:0]  index_reg;
	logic [7:0]  count_reg;
	logic [7:0]  rx_cnt_reg;
	logic        busy_reg;
	logic        nack_reg;
	logic        scl_oe_n_reg;
	logic        sda_oe_n_reg;
	logic        tick;
	logic        is_tx;
	logic        ack_out;
	logic        apb_go;
	logic        buf_hit;
	logic [4:0]  buf_idx;

	assign tick    = (div_reg == 16'(QUARTER - 1));
	assign is_tx   = (seq_reg != SQ_RCOUNT) && (seq_reg != SQ_RDATA);
	// nack the count when nothing follows, else the last data byte
	assign ack_out = (seq_reg == SQ_RCOUNT) ? (rxb_reg == 8'h00) : (k_reg == rx_cnt_reg - 8'h01);
	assign apb_go  = psel & penable & ~pready;
	assign buf_hit = (paddr >= HOST_BUF_BASE) && (paddr < HOST_BUF_BASE + 8'(4 * HOST_BUF_DEPTH));
	assign buf_idx = 5'((paddr - HOST_BUF_BASE) >> 2);

	// sda is only sampled, never the link clock, since this end makes it
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			sda_s <= 2'h3;
		else
			sda_s <= {sda_s[0], bus.sda};
	end

	// apb slave: one wait state, unmapped addresses answer with an error
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end
		else
		begin
			pready  <= apb_go;
			pslverr <= apb_go & ~(buf_hit | paddr == HOST_CTRL | paddr == HOST_STATUS);
			if (apb_go && !pwrite)
				prdata <= (paddr == HOST_STATUS) ? {16'h0, rx_cnt_reg, 6'h0, nack_reg, busy_reg} :
					(paddr == HOST_CTRL) ? {8'h0, count_reg, index_reg, 7'h0, rd_reg} :
					buf_hit ? {24'h0, buf_mem[buf_idx]} : 32'h0;
		end
	end

	// byte buffer; software writes only while the engine is idle
	always_ff @(posedge clk)
	begin
		if (apb_go && pwrite && buf_hit && !busy_reg)
			buf_mem[buf_idx] <= pwdata[7:0];
		else if (hst_reg == H_BIT && tick && q_reg == 2'd3 && bi_reg == 4'(BYTE_ACK_SLOT)
			&& seq_reg == SQ_RDATA && k_reg < 8'(HOST_BUF_DEPTH))
			buf_mem[k_reg[4:0]] <= rxb_reg;
	end

	// quarter-bit divider; scl is made here from clk
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			div_reg <= 16'h0;
		else if (tick || hst_reg == H_IDLE)
			div_reg <= 16'h0;
		else
			div_reg <= div_reg + 16'h1;
	end

	// transaction engine: start, bytes with acknowledge, stop
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hst_reg      <= H_IDLE;
			seq_reg      <= SQ_ADDRW;
			q_reg        <= 2'd0;
			bi_reg       <= 4'h0;
			txb_reg      <= 8'h0;
			rxb_reg      <= 8'h0;
			k_reg        <= 8'h0;
			rd_reg       <= 1'b0;
			index_reg    <= 8'h0;
			count_reg    <= 8'h0;
			rx_cnt_reg   <= 8'h0;
			busy_reg     <= 1'b0;
			nack_reg     <= 1'b0;
			scl_oe_n_reg <= 1'b1;
			sda_oe_n_reg <= 1'b1;
		end
		else if (hst_reg == H_IDLE)
		begin
			if (apb_go && pwrite && paddr == HOST_CTRL)
			begin
				rd_reg    <= pwdata[0];
				index_reg <= pwdata[15:8];
				count_reg <= pwdata[23:16];
				busy_reg  <= 1'b1;
				nack_reg  <= 1'b0;
				seq_reg   <= SQ_ADDRW;
				txb_reg   <= {target_addr, 1'b0};
				q_reg     <= 2'd0;
				hst_reg   <= H_START;
			end
		end
		else if (tick)
		begin
			q_reg <= q_reg + 2'd1;
			case (hst_reg)
				H_START:
				begin
					// scl low before sda rises keeps a repeated start from looking like stop
					if (q_reg == 2'd0) scl_oe_n_reg <= 1'b0;
					if (q_reg == 2'd1) sda_oe_n_reg <= 1'b1;
					if (q_reg == 2'd2) scl_oe_n_reg <= 1'b1;
					if (q_reg == 2'd3)
					begin
						sda_oe_n_reg <= 1'b0;
						bi_reg       <= 4'h0;
						hst_reg      <= H_BIT;
					end
				end
				H_BIT:
				begin
					if (q_reg == 2'd0)
					begin
						scl_oe_n_reg <= 1'b0;
						if (bi_reg == 4'(BYTE_ACK_SLOT))
							sda_oe_n_reg <= is_tx ? 1'b1 : ack_out;
						else
							sda_oe_n_reg <= is_tx ? txb_reg[7] : 1'b1;
					end
					if (q_reg == 2'd2) scl_oe_n_reg <= 1'b1;
					if (q_reg == 2'd3)
					begin
						bi_reg <= bi_reg + 4'h1;
						if (bi_reg != 4'(BYTE_ACK_SLOT))
						begin
							txb_reg <= {txb_reg[6:0], 1'b0};
							rxb_reg <= {rxb_reg[6:0], sda_s[1]};
						end
						else if (is_tx && sda_s[1])
						begin
							nack_reg <= 1'b1;
							hst_reg  <= H_STOP;
						end
						else
						begin
							bi_reg <= 4'h0;
							case (seq_reg)
								SQ_ADDRW:
								begin
									seq_reg <= SQ_INDEX;
									txb_reg <= index_reg;
								end
								SQ_INDEX:
								begin
									seq_reg <= rd_reg ? SQ_ADDRR : SQ_COUNT;
									txb_reg <= rd_reg ? {target_addr, 1'b1} : count_reg;
									if (rd_reg) hst_reg <= H_START;
								end
								SQ_COUNT:
								begin
									seq_reg <= SQ_WDATA;
									k_reg   <= 8'h0;
									txb_reg <= buf_mem[0];
									if (count_reg == 8'h0) hst_reg <= H_STOP;
								end
								SQ_WDATA:
								begin
									k_reg   <= k_reg + 8'h1;
									txb_reg <= buf_mem[5'(k_reg + 8'h1)];
									if (k_reg + 8'h1 >= count_reg) hst_reg <= H_STOP;
								end
								SQ_ADDRR:
									seq_reg <= SQ_RCOUNT;
								SQ_RCOUNT:
								begin
									rx_cnt_reg <= rxb_reg;
									k_reg      <= 8'h0;
									seq_reg    <= SQ_RDATA;
									if (rxb_reg == 8'h0) hst_reg <= H_STOP;
								end
								default:
								begin
									k_reg <= k_reg + 8'h1;
									if (ack_out) hst_reg <= H_STOP;
								end
							endcase
						end
					end
				end
				H_STOP:
				begin
					if (q_reg == 2'd0)
					begin
						scl_oe_n_reg <= 1'b0;
						sda_oe_n_reg <= 1'b0;
					end
					if (q_reg == 2'd2) scl_oe_n_reg <= 1'b1;
					if (q_reg == 2'd3)
					begin
						sda_oe_n_reg <= 1'b1;
						busy_reg     <= 1'b0;
						hst_reg      <= H_IDLE;
					end
				end
				default:
					hst_reg <= H_IDLE;
			endcase
		end
	end

	assign bus.host_scl_o    = 1'b0;
	assign bus.host_sda_o    = 1'b0;
	assign bus.host_scl_oe_n = scl_oe_n_reg;
	assign bus.host_sda_oe_n = sda_oe_n_reg;
endmodule

// ==== scb_link_checker.sv ====
// link checker: timing relations on the shared two-wire bus
`timescale 1ns/1ps
module scb_link_checker #(
	parameter int QUARTER = 6
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic host_scl_o,
	input wire logic host_scl_oe_n,
	input wire logic host_sda_o,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n,
	input wire logic scl,
	input wire logic sda
);
	logic [7:0] hi_cnt;
	logic [7:0] lo_cnt;
	logic [3:0] bit_cnt;
	logic       scl_q;
	logic       sda_q;
	// run lengths of each scl level; high count starts full so an idle bus never trips it
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hi_cnt <= 8'hff;
			lo_cnt <= 8'h00;
		end
		else
		begin
			hi_cnt <= scl ? hi_cnt + {7'h00, hi_cnt != 8'hff} : 8'h00;
			lo_cnt <= scl ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hff};
		end
	end
	// scl rises since the last start, saturating at 15
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			bit_cnt <= 4'h0;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
			if (scl && scl_q && sda_q && !sda)
				bit_cnt <= 4'h0;
			else if (scl && !scl_q && bit_cnt != 4'hf)
				bit_cnt <= bit_cnt + 4'h1;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	drive_zero_a: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
		else $error("open-drain data value not zero");
	reset_free_a: assert property ($rose(arst_n) |-> host_scl_oe_n && host_sda_oe_n && dev_sda_oe_n)
		else $error("link not released after reset");
	addr_phase_a: assert property (!dev_sda_oe_n |-> bit_cnt >= 4'h8)
		else $error("device drove sda during the address bits");
	dev_hold_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n))
		else $error("device changed sda while scl high");
	dev_late_a: assert property ($changed(dev_sda_oe_n) |-> !scl && lo_cnt <= 8'h08)
		else $error("device sda change too late after scl fall");
	start_hold_a: assert property (scl && $fell(sda) |-> scl[*5])
		else $error("scl dropped too soon after start");
	scl_high_a: assert property ($fell(scl) |-> hi_cnt >= QUARTER)
		else $error("scl high phase too short");
	scl_low_a: assert property ($rose(scl) |-> lo_cnt >= QUARTER)
		else $error("scl low phase too short");
endmodule

// ==== tb.sv ====
// self-checking bench: host and configuration port joined over one link
`timescale 1ns/1ps
module tb;
	import scb_pkg::*;
	localparam int         Q        = 6;
	localparam logic [6:0] DEV_ADDR = 7'h50;
	localparam logic [6:0] DEV_ADDR_MID = 7'h51;
	localparam logic [6:0] DEV_ADDR_HI  = 7'h52;
	localparam logic [3:0] REV      = 4'h6;  // arbitrary value
	localparam logic [3:0] MAKER    = 4'h9;  // arbitrary value
	localparam logic [7:0] DEVC     = 8'h3c; // arbitrary value
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [6:0]  target_addr = DEV_ADDR;
	logic [1:0]  sel_pin = 2'b00;
	logic [6:0]  oe_pin_n = 7'h00;
	logic [6:0]  en;
	logic [6:0]  fast;
	logic [1:0]  amp;
	logic [31:0] stat;
	logic [31:0] rdat;
	logic        err;
	int          n_mismatch = 0;
	int          check_count = 0;
	// reference register image; reserved bits already folded in
	logic [7:0]  regs_rst [8] = '{8'hff, 8'hfe, 8'hff, 8'h45, RSVD4_BITS, {REV, MAKER}, DEVC,
		{3'h0, COUNT_RESET}};
	logic [7:0]  regs [8];
	logic [7:0]  wmask [4] = '{8'hdd, 8'h23, 8'hdd, 8'h01};
	logic [7:0]  rsvd [4] = '{RSVD0_BITS, RSVD1_BITS, RSVD2_BITS, RSVD3_BITS};
	scb_if u_scb_if ();
	scb_dev #(.ADDR_LOW(DEV_ADDR), .ADDR_MID(DEV_ADDR_MID), .ADDR_HIGH(DEV_ADDR_HI),
		.REV_CODE(REV), .MAKER_CODE(MAKER), .DEV_CODE(DEVC)) u_scb_dev (
		.clk(clk), .arst_n(arst_n), .bus(u_scb_if), .target_address_select_pin(sel_pin),
		.clock_out_enable_pin_n(oe_pin_n), .differential_clock_output_en(en),
		.edge_speed_fast(fast), .amplitude_sel(amp));
	scb_host #(.QUARTER(Q)) u_scb_host (
		.clk(clk), .arst_n(arst_n), .bus(u_scb_if), .target_addr(target_addr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	scb_link_checker #(.QUARTER(Q)) u_scb_link_checker (
		.clk(clk), .arst_n(arst_n), .host_scl_o(u_scb_if.host_scl_o),
		.host_scl_oe_n(u_scb_if.host_scl_oe_n), .host_sda_o(u_scb_if.host_sda_o),
		.host_sda_oe_n(u_scb_if.host_sda_oe_n), .dev_sda_o(u_scb_if.dev_sda_o),
		.dev_sda_oe_n(u_scb_if.dev_sda_oe_n), .scl(u_scb_if.scl), .sda(u_scb_if.sda));
	always #5 clk = ~clk;
	task automatic conclude;
		if (n_mismatch == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic stall;
		n_mismatch++;
		conclude();
	endtask
	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20)
			stall();
	endtask
	// start a link transaction and poll until the host is idle again
	task automatic xfer(input logic rd, input logic [7:0] n, input logic [7:0] x);
		int i;
		apb(1'b1, HOST_CTRL, {8'h00, x, n, 7'h00, rd});
		for (i = 0; i < 3000; i++)
		begin
			apb(1'b0, HOST_STATUS, 32'h0);
			if (rdat[0] === 1'b0)
				break;
		end
		stat = rdat;
		if (i == 3000)
			stall();
	endtask
	task automatic wr_block(input logic [7:0] n, input logic [7:0] b [$]);
		int i;
		int idx;
		for (i = 0; i < b.size(); i++)
			apb(1'b1, HOST_BUF_BASE + 8'(4 * i), {24'h0, b[i]});
		xfer(1'b0, n, 8'(b.size()));
		check("write nack", stat[1], 1'b0);
		for (i = 0; i < b.size(); i++)
		begin
			idx = n + i;
			if (idx < 4)
				regs[idx] = (b[i] & wmask[idx]) | rsvd[idx];
			else if (idx == 7)
				regs[7] = {3'h0, b[i][4:0]};
		end
	endtask
	// block read from n; count byte first, then bytes n onward
	task automatic rd_block(input logic [7:0] n);
		int i;
		xfer(1'b1, n, 8'h00);
		check("read nack", stat[1], 1'b0);
		check("count byte", stat[15:8], regs[7]);
		for (i = 0; i < regs[7]; i++)
		begin
			apb(1'b0, HOST_BUF_BASE + 8'(4 * i), 32'h0);
			check("read byte", rdat[7:0], (n + i < 8) ? regs[n + i] : 8'h00);
		end
	endtask
	task automatic chk_outs;
		logic [6:0] en_exp;
		en_exp = {regs[1][5], regs[0][7:6], regs[0][4:2], regs[0][0]} & ~oe_pin_n;
		check("output enables", en, en_exp);
		check("edge speed", fast, {regs[3][0], regs[2][7:6], regs[2][4:2], regs[2][0]});
		check("amplitude", amp, regs[1][1:0]);
	endtask
	task automatic t_reset;
		repeat (6) @(posedge clk);
		chk_outs();
		rd_block(8'h00);
	endtask
	// reserved bits set in the data, and reg4 written too
	task automatic t_write;
		wr_block(8'h00, '{8'h5a, 8'h01, 8'ha4, 8'hfe, 8'h00});
		chk_outs();
		rd_block(8'h00);
	endtask
	task automatic t_pin;
		oe_pin_n <= 7'h55;
		repeat (8) @(posedge clk);
		chk_outs();
		oe_pin_n <= 7'h00;
		repeat (8) @(posedge clk);
		chk_outs();
	endtask
	// shorter readback count, read over the top of the map
	task automatic t_count;
		wr_block(8'h07, '{8'he3});
		rd_block(8'h05);
		rd_block(8'h07);
	endtask
	// select pin moved after reset must not change the address
	task automatic t_addr;
		sel_pin <= 2'b11;
		target_addr <= DEV_ADDR_HI;
		xfer(1'b1, 8'h00, 8'h00);
		check("foreign address nack", stat[1], 1'b1);
		apb(1'b0, 8'h08, 32'h0);
		check("unmapped error", err, 1'b1);
		check("unmapped data", rdat, 32'h0);
		target_addr <= DEV_ADDR;
		wr_block(8'h02, '{8'h00, 8'h00});
		chk_outs();
	endtask
	// mid-run reset: the select pin is caught afresh and registers return to defaults
	task automatic t_rearm(input logic [1:0] sel, input logic [6:0] a);
		sel_pin <= sel;
		target_addr <= a;
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		regs = regs_rst;
		repeat (4) @(posedge clk);
		sel_pin <= 2'b00;
		rd_block(8'h00);
		check("rearmed address nack", stat[1], 1'b0);
		chk_outs();
	endtask
	initial
	begin
		regs = regs_rst;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_write();
		t_pin();
		t_count();
		t_addr();
		t_rearm(2'b01, DEV_ADDR_MID);
		t_rearm(2'b11, DEV_ADDR_HI);
		conclude();
	end
endmodule
